/* File: core/port_io_cfg.svh */
`ifndef PORT_IO_CFG_SVH
`define PORT_IO_CFG_SVH

// ***************************************************
// Register offsets (word index on the plain port)
// ***************************************************
`define GP_OUT_DATA_ADDR  4'h0
`define GP_DIR_ADDR       4'h1
`define PORT_MODE_ADDR    4'h2
`define GP_IN_ADDR        4'h3
`define INP_IN_ADDR       4'h4
`define IRQ_STATUS_ADDR   4'h5
`define IRQ_MASK_ADDR     4'h6

// ***************************************************
// Mode register field positions
// ***************************************************
`define MODE_OPEN_DRAIN_BIT 0
`define MODE_ANALOG_BIT     1
`define MODE_STOP_BIT       2

// ***************************************************
// Reset values
// ***************************************************
`define GP_OUT_DATA_RST 8'h00
`define GP_DIR_RST      8'h00
`define PORT_MODE_RST   3'h0
`define IRQ_MASK_RST    4'h0

// ***************************************************
// Timing counts
// ***************************************************
`define SYNC_STAGES 2

`endif

/* File: core/port_io_pkg.sv */
package port_io_pkg;

	// Drive style shared by all output lines of the general port
	typedef enum logic {
		DRIVE_PUSH_PULL,
		DRIVE_OPEN_DRAIN
	} drive_mode_t;

	// Source selection for the first two input lines; the third stays digital
	typedef enum logic {
		INPUT_DIGITAL,
		INPUT_ANALOG
	} input_mode_t;

endpackage

/* File: core/bit_sync.sv */
`timescale 1ns/10ps
`include "port_io_cfg.svh"

// ***************************************************
// Two-stage synchroniser for a vector of levels
// ***************************************************
module bit_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             mclk_in,
	input  wire logic             reset_n_in,
	// Asynchronous levels in
	input  wire logic [WIDTH-1:0] async_in,
	// Synchronised levels out
	output logic      [WIDTH-1:0] sync_out
);

	initial begin
		if (WIDTH < 1)
			$error("bit_sync: WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] stage1;      // First stage, read only by stage two
	logic [WIDTH-1:0] next_stage1; // Next value of first stage
	logic [WIDTH-1:0] next_sync;   // Next value of second stage

	// Next values: reset clears both stages
	always_comb begin
		if (!reset_n_in) begin
			next_stage1 = '0;
			next_sync   = '0;
		end else begin
			next_stage1 = async_in;
			next_sync   = stage1;
		end
	end

	// Register both stages
	always_ff @(posedge mclk_in) begin
		stage1   <= next_stage1;
		sync_out <= next_sync;
	end

endmodule

/* File: core/edge_detect.sv */
`timescale 1ns/10ps

// ***************************************************
// Rise and fall detector for synchronised levels
// ***************************************************
module edge_detect #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             mclk_in,
	input  wire logic             reset_n_in,
	// Synchronised levels
	input  wire logic [WIDTH-1:0] level_in,
	// One-cycle edge pulses
	output logic      [WIDTH-1:0] rise_out,
	output logic      [WIDTH-1:0] fall_out
);

	initial begin
		if (WIDTH < 1)
			$error("edge_detect: WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] last;      // Level one cycle ago
	logic [WIDTH-1:0] next_last; // Next held level

	// Hold previous level; reset clears it
	always_comb begin
		next_last = reset_n_in ? level_in : '0;
	end

	always_ff @(posedge mclk_in) begin
		last <= next_last;
	end

	// Combinational pulses, one cycle per edge
	assign rise_out = level_in & ~last;
	assign fall_out = ~level_in & last;

endmodule

/* File: core/port_io_comparator_irq.sv */
// Notes on behaviour
// - Eight bidirectional general port lines
// - Each general line direction set independently
// - One global push-pull or open-drain setting
// - Three input-only lines, no drivers
// - First two input lines digital or analog by software
// - Input lines feed interrupts and timer input
// - Two comparators share third line reference
// - Second comparator requests on both edges
// - First comparator requests on falling edge
// - Analog mode outside stop: comparator results replace pins
// - Comparators off: reference line requests on falling edge again
// - Comparators unpowered during stop state
// - Requests 0..3 mapped to documented edges
`timescale 1ns/10ps
`include "port_io_cfg.svh"

module port_io_comparator_irq #(
	parameter int GP_WIDTH  = 8,
	parameter int INP_WIDTH = 3
) (
	// Clock and reset
	input  wire logic                 mclk_in,
	input  wire logic                 reset_n_in,
	// Register port
	input  wire logic [3:0]           reg_addr_in,
	input  wire logic [7:0]           reg_wdata_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	output logic      [7:0]           reg_rdata_out,
	// General port lines
	input  wire logic [GP_WIDTH-1:0]  general_port_lines_in,
	output logic      [GP_WIDTH-1:0]  general_port_lines_out,
	output logic      [GP_WIDTH-1:0]  general_port_lines_oe_n_out,
	// Input port lines, digital levels
	input  wire logic [INP_WIDTH-1:0] input_port_lines_in,
	// Analog comparator results from the pad macro
	input  wire logic                 first_compare_in,
	input  wire logic                 second_compare_in,
	// Analog front end control
	output logic                      comparator_power_out,
	output logic                      analog_select_out,
	// Request pulses, timer input and interrupt
	output logic      [3:0]           external_interrupt_requests_out,
	output logic                      timer_input_out,
	output logic                      irq_out
);

	initial begin
		if (GP_WIDTH != 8 || INP_WIDTH != 3)
			$error("port_io: only 8 general and 3 input lines");
		if (`SYNC_STAGES != 2)
			$error("port_io: synchronisers are two stages deep");
	end

	// ***************************************************
	// Register state
	// ***************************************************
	logic [GP_WIDTH-1:0] gp_out_data;      // Output latch
	logic [GP_WIDTH-1:0] gp_dir;           // 1 = output
	logic [2:0]          port_mode;        // Drive, analog, stop
	logic [3:0]          irq_status;       // Sticky request bits
	logic [3:0]          irq_mask;         // Enables for irq_out
	logic [GP_WIDTH-1:0] next_gp_out_data;
	logic [GP_WIDTH-1:0] next_gp_dir;
	logic [2:0]          next_port_mode;
	logic [3:0]          next_irq_status;
	logic [3:0]          next_irq_mask;
	logic [7:0]          next_rdata;

	// ***************************************************
	// Mode decode
	// ***************************************************
	// The mode register holds three loose control bits. Drive style
	// applies to every output line at once; there is no per-line
	// choice. Analog selection and the stop bit together decide
	// whether the comparator pair counts at all.
	// Decoded mode fields
	port_io_pkg::drive_mode_t drive_mode;
	port_io_pkg::input_mode_t input_mode;
	logic                     stop_state;

	assign drive_mode = port_io_pkg::drive_mode_t'(
		port_mode[`MODE_OPEN_DRAIN_BIT]);
	assign input_mode = port_io_pkg::input_mode_t'(
		port_mode[`MODE_ANALOG_BIT]);
	assign stop_state = port_mode[`MODE_STOP_BIT];

	// ***************************************************
	// Synchronisers and edge detection
	// ***************************************************
	logic [GP_WIDTH-1:0]  gp_sync;   // General lines, synchronised
	logic [INP_WIDTH-1:0] inp_sync;  // Digital input lines
	logic [1:0]           cmp_sync;  // Comparator 1 and 2 results
	logic [INP_WIDTH-1:0] src_level; // Selected line levels
	logic [INP_WIDTH-1:0] src_rise;
	logic [INP_WIDTH-1:0] src_fall;
	logic                 cmp_active; // Comparators powered, analog

	// Every pin level is asynchronous to the clock, so nothing reads
	// it before two flops. The cost is a fixed latency of two cycles
	// on every read and every request, which software never sees as
	// anything but a slightly later event.
	bit_sync #(.WIDTH(GP_WIDTH)) u_gp_sync (
		.mclk_in    (mclk_in),
		.reset_n_in (reset_n_in),
		.async_in   (general_port_lines_in),
		.sync_out   (gp_sync)
	);

	// Pins and comparator results are both synchronised
	bit_sync #(.WIDTH(INP_WIDTH + 2)) u_inp_sync (
		.mclk_in    (mclk_in),
		.reset_n_in (reset_n_in),
		.async_in   ({second_compare_in, first_compare_in,
		               input_port_lines_in}),
		.sync_out   ({cmp_sync, inp_sync})
	);

	// Comparators only count while powered; in stop they are dead
	// Stop takes priority over analog: an unpowered comparator gives
	// no trustworthy result, so the lines fall back to their pins.
	assign cmp_active = (input_mode == port_io_pkg::INPUT_ANALOG)
	                    && !stop_state;

	// Select comparator results or raw pins per line
	always_comb begin
		src_level = inp_sync;
		if (cmp_active) begin
			src_level[0] = cmp_sync[0];
			src_level[1] = cmp_sync[1];
		end
		// Reference line always stays a digital input
		src_level[2] = inp_sync[2];
	end

	// Edges are taken on the selected level, once per change
	edge_detect #(.WIDTH(INP_WIDTH)) u_edges (
		.mclk_in    (mclk_in),
		.reset_n_in (reset_n_in),
		.level_in   (src_level),
		.rise_out   (src_rise),
		.fall_out   (src_fall)
	);

	// ***************************************************
	// Request mapping
	// ***************************************************
	logic [3:0] req_now; // Combinational request pulses

	// A pin change shows as a request three edges later: two for the
	// synchroniser, one for the output register; the edge detector is
	// combinational. The status bit is set at the same edge as the pulse,
	// so the level interrupt follows one cycle after it.

	// Request 1 is suppressed while the line serves as reference
	always_comb begin
		req_now[0] = src_fall[1];
		req_now[1] = src_fall[2] && !cmp_active;
		req_now[2] = src_fall[0];
		req_now[3] = src_rise[1];
	end

	// ***************************************************
	// Helpers
	// ***************************************************
	// Widens a four-bit field to a read byte with zero upper bits
	function automatic logic [7:0] pad_nibble(input logic [3:0] v);
		pad_nibble = {4'h0, v};
	endfunction

	// Widens an input-line vector to a read byte
	function automatic logic [7:0] pad_lines(
		input logic [INP_WIDTH-1:0] v);
		pad_lines = {{(8-INP_WIDTH){1'b0}}, v};
	endfunction

	// ***************************************************
	// Register port: next values
	// ***************************************************
	always_comb begin
		next_gp_out_data = gp_out_data;
		next_gp_dir      = gp_dir;
		next_port_mode   = port_mode;
		next_irq_mask    = irq_mask;
		next_irq_status  = irq_status;
		next_rdata       = 8'h00;
		// Read side: data valid the cycle after the strobe
		if (reg_rd_in) begin
			case (reg_addr_in)
			`GP_OUT_DATA_ADDR: next_rdata = gp_out_data;
			`GP_DIR_ADDR:      next_rdata = gp_dir;
			`PORT_MODE_ADDR:   next_rdata = {5'h00, port_mode};
			`GP_IN_ADDR:       next_rdata = gp_sync;
			`INP_IN_ADDR:      next_rdata = pad_lines(src_level);
			`IRQ_STATUS_ADDR: begin
				next_rdata      = pad_nibble(irq_status);
				next_irq_status = 4'h0; // Clear on read
			end
			`IRQ_MASK_ADDR:    next_rdata = pad_nibble(irq_mask);
			default:           next_rdata = 8'h00;
			endcase
		end
		// Write side; unmapped addresses are ignored
		if (reg_wr_in) begin
			case (reg_addr_in)
			`GP_OUT_DATA_ADDR: next_gp_out_data = reg_wdata_in;
			`GP_DIR_ADDR:      next_gp_dir = reg_wdata_in;
			`PORT_MODE_ADDR:   next_port_mode = reg_wdata_in[2:0];
			`IRQ_MASK_ADDR:    next_irq_mask = reg_wdata_in[3:0];
			default:           next_gp_dir = gp_dir;
			endcase
		end
		// A new event wins over a clear in the same cycle. Losing it
		// would hide an edge that software can never see again, while
		// a bit seen twice only costs one extra status read.
		next_irq_status = next_irq_status | req_now;
		if (!reset_n_in) begin
			next_gp_out_data = `GP_OUT_DATA_RST;
			next_gp_dir      = `GP_DIR_RST;
			next_port_mode   = `PORT_MODE_RST;
			next_irq_mask    = `IRQ_MASK_RST;
			next_irq_status  = 4'h0;
			next_rdata       = 8'h00;
		end
	end

	// Register the port state; reset is folded into the next values,
	// so this process only copies them
	always_ff @(posedge mclk_in) begin
		gp_out_data   <= next_gp_out_data;
		gp_dir        <= next_gp_dir;
		port_mode     <= next_port_mode;
		irq_mask      <= next_irq_mask;
		irq_status    <= next_irq_status;
		reg_rdata_out <= next_rdata;
	end

	// ***************************************************
	// Pin drivers and registered outputs
	// ***************************************************
	logic [GP_WIDTH-1:0] next_pin_out;
	logic [GP_WIDTH-1:0] next_pin_oe_n;
	logic [3:0]          next_req;
	logic                next_timer;
	logic                next_irq;
	logic                next_power;
	logic                next_analog;

	logic [GP_WIDTH-1:0] line_drive; // Level each line would drive
	logic [GP_WIDTH-1:0] line_oe_n;  // Per-line enable, low = driving
	logic                open_drain; // Shared drive style, one for all

	// One global style for every output line
	assign open_drain = (drive_mode == port_io_pkg::DRIVE_OPEN_DRAIN);

	// Each line decides alone from its own direction bit, so one
	// line set to input never disturbs its neighbours. Open drain
	// only ever pulls low: a one releases the line to the board.
	genvar gi;
	generate
		for (gi = 0; gi < GP_WIDTH; gi++) begin : g_line
			// Drive value: latch in push-pull, zero in open drain
			assign line_drive[gi] = open_drain ? 1'b0
				: gp_out_data[gi];
			// Enable: any output in push-pull, zeros in open drain
			assign line_oe_n[gi] = open_drain
				? ~(gp_dir[gi] & ~gp_out_data[gi])
				: ~gp_dir[gi];
		end
	endgenerate

	// Registered outputs take the per-line decision
	always_comb begin
		next_pin_out  = line_drive;
		next_pin_oe_n = line_oe_n;
		// Input lines have no drivers at all
		next_req    = req_now;
		next_timer  = src_level[0];
		next_irq    = |(irq_status & irq_mask);
		next_power  = cmp_active;
		next_analog = input_mode == port_io_pkg::INPUT_ANALOG;
		if (!reset_n_in) begin
			next_pin_out  = {GP_WIDTH{1'b0}};
			next_pin_oe_n = {GP_WIDTH{1'b1}};
			next_req      = 4'h0;
			next_timer    = 1'b0;
			next_irq      = 1'b0;
			next_power    = 1'b0;
			next_analog   = 1'b0;
		end
	end

	// Every output leaves straight from a flop, so the pads and the
	// interrupt controller never see a combinational glitch; the
	// price is one more cycle of latency on each of them.
	always_ff @(posedge mclk_in) begin
		general_port_lines_out          <= next_pin_out;
		general_port_lines_oe_n_out     <= next_pin_oe_n;
		external_interrupt_requests_out <= next_req;
		timer_input_out                 <= next_timer;
		irq_out                         <= next_irq;
		comparator_power_out            <= next_power;
		analog_select_out               <= next_analog;
	end

endmodule

/* File: dv/port_io_comparator_irq_monitor.sv */
`timescale 1ns/10ps
// ******************************
// Port-level checker
// ******************************
module port_io_monitor #(
	parameter int INP_WIDTH = 3
) (
	// Clock and reset
	input wire logic                 mclk_in,
	input wire logic                 reset_n_in,
	// Register port
	input wire logic [3:0]           reg_addr_in,
	input wire logic                 reg_rd_in,
	input wire logic [7:0]           reg_rdata_out,
	// Input side
	input wire logic [INP_WIDTH-1:0] input_port_lines_in,
	input wire logic                 first_compare_in,
	// Outputs watched
	input wire logic                 comparator_power_out,
	input wire logic                 analog_select_out,
	input wire logic [3:0]           external_interrupt_requests_out,
	input wire logic                 timer_input_out
);
	// One clock domain, so one default clock and reset
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);

	pulse_once_a: assert property (
		(external_interrupt_requests_out
		& $past(external_interrupt_requests_out)) == 4'h0)
		else $error("request pulse longer than one cycle");
	req_pair_a: assert property (
		(external_interrupt_requests_out & 4'h9) != 4'h9)
		else $error("rise and fall of one line together");
	// Pipeline of the old source drains within five cycles
	ref_block_a: assert property (
		comparator_power_out [*6] |-> !external_interrupt_requests_out[1])
		else $error("reference request while analog active");
	power_sel_a: assert property (
		comparator_power_out |-> analog_select_out)
		else $error("comparators powered outside analog mode");
	timer_pin_a: assert property (
		(!comparator_power_out && $stable(input_port_lines_in[0])) [*6]
		|-> timer_input_out == input_port_lines_in[0])
		else $error("timer input not following pin");
	timer_cmp_a: assert property (
		(comparator_power_out && $stable(first_compare_in)) [*6]
		|-> timer_input_out == first_compare_in)
		else $error("timer input not following comparator");
	rdata_idle_a: assert property (
		!reg_rd_in |=> reg_rdata_out == 8'h00)
		else $error("read data outside read cycle");
	unmapped_a: assert property (
		reg_rd_in && reg_addr_in > 4'h6 |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
endmodule

bind port_io_comparator_irq port_io_monitor #(.INP_WIDTH(INP_WIDTH)) mon (
	.mclk_in(mclk_in), .reset_n_in(reset_n_in),
	.reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out),
	.input_port_lines_in(input_port_lines_in),
	.first_compare_in(first_compare_in),
	.comparator_power_out(comparator_power_out),
	.analog_select_out(analog_select_out),
	.external_interrupt_requests_out(external_interrupt_requests_out),
	.timer_input_out(timer_input_out)
);

/* File: dv/pin_board_model.sv */
`timescale 1ns/10ps
// ******************************
// Board and analog pad model
// ******************************
module pin_board_model (
	// Clock and device controls
	input  wire logic       mclk_in,
	input  wire logic       power_in,
	input  wire logic [7:0] drive_in,
	input  wire logic [7:0] oe_n_in,
	// Board levels, analog as 8-bit codes
	input  wire logic [7:0] board_in,
	input  wire logic [7:0] an1_in,
	input  wire logic [7:0] an2_in,
	input  wire logic [7:0] ref_in,
	// Pin levels seen by the device
	output logic      [7:0] pins_out,
	output logic      [2:0] lines_out,
	output logic            cmp1_out,
	output logic            cmp2_out
);
	logic [1:0] last = 2'b00; // Last powered results

	// Released lines show the board level
	assign pins_out = (drive_in & ~oe_n_in) | (board_in & oe_n_in);
	// Digital threshold at mid scale
	assign lines_out = {ref_in[7], an2_in[7], an1_in[7]};
	// Unpowered pair shows the inverse of its last result
	always_ff @(posedge mclk_in) begin
		if (power_in) begin
			last <= {an2_in > ref_in, an1_in > ref_in};
		end
	end
	assign cmp1_out = power_in ? an1_in > ref_in : ~last[0];
	assign cmp2_out = power_in ? an2_in > ref_in : ~last[1];
endmodule

/* File: dv/port_io_comparator_irq_test.sv */
`timescale 1ns/10ps
module port_io_comparator_irq_test;
	// ******************************
	// Signals
	// ******************************
	logic       mclk_in = 1'b0;
	logic       reset_n_in = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr_s = 1'b0;
	logic       rd_s = 1'b0;
	logic [7:0] board = 8'h3C;
	logic [7:0] an1 = 8'h20;
	logic [7:0] an2 = 8'h20;
	logic [7:0] rf = 8'hF0;
	logic [3:0] mask = 4'h0;    // Bench copy of the mask
	logic [7:0] rdata, pins, out, oe_n;
	logic [3:0] req;
	logic [2:0] lines;
	logic       cmp1, cmp2, power, sel, timer, irq;
	int         miscompares = 0;
	int         samples_checked = 0;

	initial forever #12.5 mclk_in = ~mclk_in;

	port_io_comparator_irq uut (
		.mclk_in(mclk_in), .reset_n_in(reset_n_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
		.reg_rd_in(rd_s), .reg_rdata_out(rdata),
		.general_port_lines_in(pins), .general_port_lines_out(out),
		.general_port_lines_oe_n_out(oe_n), .input_port_lines_in(lines),
		.first_compare_in(cmp1), .second_compare_in(cmp2),
		.comparator_power_out(power), .analog_select_out(sel),
		.external_interrupt_requests_out(req), .timer_input_out(timer),
		.irq_out(irq));
	pin_board_model board_m (
		.mclk_in(mclk_in), .power_in(power), .drive_in(out),
		.oe_n_in(oe_n), .board_in(board), .an1_in(an1), .an2_in(an2),
		.ref_in(rf), .pins_out(pins), .lines_out(lines),
		.cmp1_out(cmp1), .cmp2_out(cmp2));

	// ******************************
	// Shared tasks
	// ******************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge mclk_in);
		wr_s <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge mclk_in);
		rd_s <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	// New levels, then every pulse, the interrupt and the status
	task automatic ev(input logic [7:0] n1, n2, nr, input logic [3:0] e);
		logic [3:0] seen;
		logic [3:0] dup;
		seen = 4'h0;
		dup = 4'h0;
		an1 <= n1;
		an2 <= n2;
		rf <= nr;
		repeat (10) begin
			@(posedge mclk_in);
			#1 dup |= req & seen;
			seen |= req;
		end
		chk({dup, seen}, {4'h0, e});
		chk({7'h0, irq}, {7'h0, |(e & mask)});
		rd(4'h5, {4'h0, e});
		@(posedge mclk_in);
		#1 chk({7'h0, irq}, 8'h00);
	endtask
	task automatic close_out();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ******************************
	// Scenarios
	// ******************************
	task automatic t_reset();
		#1 chk(oe_n, 8'hFF);
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h00);
		rd(4'h2, 8'h00);
		rd(4'h6, 8'h00);
	endtask
	task automatic t_port();
		wr(4'h0, 8'hA5);
		wr(4'h1, 8'h0F);
		repeat (4) @(posedge mclk_in);
		#1 chk(oe_n, 8'hF0);
		chk(out & 8'h0F, 8'h05);
		rd(4'h3, 8'h35);
		wr(4'h2, 8'h01);
		wr(4'h3, 8'hFF);
		repeat (4) @(posedge mclk_in);
		#1 chk(oe_n, 8'hF5);
		chk(out, 8'h00);
		rd(4'h3, 8'h34);
		rd(4'hF, 8'h00);
		wr(4'h2, 8'h00);
	endtask
	task automatic t_digital();
		wr(4'h6, 8'h0F);
		mask = 4'hF;
		ev(8'h20, 8'h20, 8'h10, 4'h2);
		ev(8'hF0, 8'h20, 8'h10, 4'h0);
		chk({7'h0, timer}, 8'h01);
		ev(8'h20, 8'h20, 8'h10, 4'h4);
		ev(8'h20, 8'hF0, 8'h10, 4'h8);
		ev(8'h20, 8'h20, 8'h10, 4'h1);
		rd(4'h4, 8'h00);
	endtask
	task automatic t_analog();
		wr(4'h2, 8'h02);
		ev(8'h20, 8'h20, 8'h10, 4'h8);
		chk({6'h0, power, sel}, 8'h03);
		ev(8'h20, 8'h20, 8'hF0, 4'h5);
		ev(8'h20, 8'h20, 8'h10, 4'h8);
		chk({7'h0, timer}, 8'h01);
		rd(4'h4, 8'h03);
		ev(8'h05, 8'h20, 8'h10, 4'h4);
		ev(8'h20, 8'h20, 8'h10, 4'h0);
	endtask
	task automatic t_stop();
		wr(4'h2, 8'h06);
		ev(8'h20, 8'h20, 8'h10, 4'h5);
		chk({7'h0, power}, 8'h00);
		ev(8'h20, 8'hF0, 8'h10, 4'h8);
		wr(4'h6, 8'h00);
		mask = 4'h0;
		wr(4'h2, 8'h00);
		ev(8'h20, 8'hF0, 8'hF0, 4'h0);
		ev(8'h20, 8'hF0, 8'h10, 4'h2);
	endtask

	// ******************************
	// Sequence and watchdog
	// ******************************
	initial begin
		repeat (4) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		t_reset();
		t_port();
		t_digital();
		t_analog();
		t_stop();
		close_out();
	end
	// Whole run needs about 230 cycles
	initial begin
		#50000;
		miscompares++;
		close_out();
	end
endmodule
